// *** src/rsc_pkg.sv ***
// Shared constants of the reset source controller.
package rsc_pkg;

  // Clock and timing.
  localparam int unsigned MCLK_FREQ_MHZ   = 125;
  localparam int unsigned MCLK_PERIOD_PS  = 8000;
  localparam int unsigned MCD_TIMEOUT_US  = 100;
  localparam int unsigned MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * MCLK_FREQ_MHZ;
  // The release delay is 5.0 us, held here in nanoseconds.
  localparam int unsigned RST_DELAY_NS    = 5000;
  localparam int unsigned RST_DELAY_CYC   = (RST_DELAY_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int unsigned RST_DELAY_W     = 10;
  localparam int unsigned MCD_CNT_W       = 16;
  localparam int unsigned WDT_CLK_DIV     = 12;
  localparam int unsigned WDT_DIV_W       = 4;

  // Reset cause register bit positions.
  localparam int unsigned BIT_PIN  = 0;
  localparam int unsigned BIT_POR  = 1;
  localparam int unsigned BIT_MCD  = 2;
  localparam int unsigned BIT_WDT  = 3;
  localparam int unsigned BIT_SW   = 4;
  localparam int unsigned BIT_CMP  = 5;
  localparam int unsigned BIT_FERR = 6;

  // Reset values.
  localparam logic [7:0]  CAUSE_RESET_VALUE = 8'h02;
  localparam logic [15:0] RESET_VECTOR      = 16'h0000;

  // Flash size selection and user code limits.
  localparam logic [1:0]  SIZE_8K    = 2'h0;
  localparam logic [1:0]  SIZE_4K    = 2'h1;
  localparam logic [1:0]  SIZE_2K    = 2'h2;
  localparam logic [15:0] LIMIT_8K   = 16'h1dff;
  localparam logic [15:0] LIMIT_4K   = 16'h0fff;
  localparam logic [15:0] LIMIT_2K   = 16'h07ff;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_HOLD  = 3'b010,
    ST_DELAY = 3'b100
  } rsc_state_type;

endpackage

// *** src/rsc_clk_if.sv ***
// Carrier between the sequencer and the system clock watcher.
`timescale 1ns/100ps
interface rsc_clk_if;
  logic detect_en;
  logic clock_missing;
  logic wdt_tick;

  modport watch (
    input  detect_en,
    output clock_missing,
    output wdt_tick
  );

  modport ctrl (
    output detect_en,
    input  clock_missing,
    input  wdt_tick
  );
endinterface

// *** src/rsc_clock_watch.sv ***
// Clock loss detector and divide-by-12 watchdog prescaler on the system clock.
`timescale 1ns/100ps
module rsc_clock_watch #(
  parameter int unsigned MCD_CYC = rsc_pkg::MCD_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Observed system clock
  input  wire logic system_clock_i,
  // Sequencer side
  rsc_clk_if.watch  cw
);

  logic                               system_clock_q;
  logic [rsc_pkg::MCD_CNT_W-1:0]      idle_cnt_q;
  logic [rsc_pkg::WDT_DIV_W-1:0]      div_cnt_q;
  logic                               missing_q;
  logic                               tick_q;
  wire                                rise;
  wire                                expired;
  wire                                div_wrap;

  // The system clock must be well below half of mclk_i to be seen at all.
  assign rise     = system_clock_i & ~system_clock_q;
  assign expired  = idle_cnt_q >= rsc_pkg::MCD_CNT_W'(MCD_CYC - 1);
  assign div_wrap = div_cnt_q == rsc_pkg::WDT_DIV_W'(rsc_pkg::WDT_CLK_DIV - 1);

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      system_clock_q   <= 1'b0;
      idle_cnt_q <= '0;
      missing_q  <= 1'b0;
    end else begin
      system_clock_q   <= system_clock_i;
      idle_cnt_q <= (rise || !cw.detect_en) ? '0 : (expired ? idle_cnt_q : idle_cnt_q + 1'b1);
      missing_q  <= cw.detect_en && !rise && expired;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= rise ? (div_wrap ? '0 : div_cnt_q + 1'b1) : div_cnt_q;
      tick_q    <= rise && div_wrap;
    end
  end

  assign cw.clock_missing = missing_q;
  assign cw.wdt_tick      = tick_q;

endmodule

// *** src/rsc_reset_source_controller.sv ***
// Reset source controller: cause register, reset sequencing and release delay.
`timescale 1ns/100ps
module rsc_reset_source_controller #(
  parameter int unsigned MCD_CYC = rsc_pkg::MCD_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Special function register port
  input  wire logic        sfr_sel_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  // Analog and timer sources
  input  wire logic        por_i,
  input  wire logic        vdd_low_i,
  input  wire logic        system_clock_i,
  input  wire logic        cmp_out_i,
  input  wire logic        wdt_timeout_i,
  // Flash access monitor
  input  wire logic [1:0]  size_sel_i,
  input  wire logic        program_store_write_enable_i,
  input  wire logic        movx_wr_i,
  input  wire logic [15:0] movx_addr_i,
  input  wire logic        movc_rd_i,
  input  wire logic [15:0] movc_addr_i,
  input  wire logic        branch_fetch_i,
  input  wire logic [15:0] fetch_addr_i,
  // External reset pin, open drain
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_o,
  // System side
  output logic             sys_rst_o,
  output logic             cpu_run_o,
  output logic      [15:0] reset_vector_o,
  output logic             vdd_mon_en_o,
  output logic             wdt_restart_o,
  output logic             wdt_tick_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  rsc_pkg::rsc_state_type            state_q;
  rsc_pkg::rsc_state_type            state_d;
  logic [rsc_pkg::RST_DELAY_W-1:0]   dly_cnt_q;
  logic [rsc_pkg::RST_DELAY_W-1:0]   dly_cnt_d;
  logic [7:0]                        pend_q;
  logic [7:0]                        pend_d;
  logic [7:0]                        cause_q;
  logic [7:0]                        cause_d;
  logic                              mcd_en_q;
  logic                              cmp_en_q;
  logic                              mon_en_q;
  logic                              mcd_en_d;
  logic                              cmp_en_d;
  logic                              mon_en_d;
  logic [7:0]                        rdata_q;
  logic                              pin_oe_q;
  logic                              pin_out_q;
  logic                              sys_rst_q;
  logic                              run_q;
  logic [15:0]                       vector_q;
  logic                              wdt_restart_q;
  logic                              wdt_tick_q;

  wire                               in_run;
  wire                               reg_wr;
  wire                               lvl_por;
  wire                               lvl_mon;
  wire                               lvl_pin;
  wire                               lvl_mcd;
  wire                               lvl_cmp;
  wire                               ev_mon;
  wire                               ev_sw;
  wire                               ev_wdt;
  wire                               ev_ferr;
  wire                               ferr_wr;
  wire                               ferr_rd;
  wire                               ferr_fetch;
  wire                               any_level;
  wire                               power_grp;
  wire                               trigger;
  wire                               dly_done;
  wire  [7:0]                        new_cause;

  rsc_clk_if cw ();

  ////////////////////////////////////////////////////////////////////////////////
  // User code limit check, shared by all three flash access paths.

  function automatic logic above_limit(input logic [15:0] addr, input logic [1:0] sel);
    logic [15:0] limit;
    limit = rsc_pkg::LIMIT_2K;
    unique case (sel)
      rsc_pkg::SIZE_8K: limit = rsc_pkg::LIMIT_8K;
      rsc_pkg::SIZE_4K: limit = rsc_pkg::LIMIT_4K;
      rsc_pkg::SIZE_2K: limit = rsc_pkg::LIMIT_2K;
      default:          limit = rsc_pkg::LIMIT_2K;
    endcase
    return addr > limit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Source decode

  assign in_run    = state_q == rsc_pkg::ST_RUN;
  // The CPU is halted during reset, so register writes only count while running.
  assign reg_wr    = sfr_sel_i && sfr_wr_i && in_run;

  assign lvl_por   = por_i;
  assign lvl_mon   = mon_en_q && vdd_low_i;
  assign lvl_pin   = !rst_pin_i && !pin_oe_q;
  assign lvl_mcd   = cw.clock_missing;
  assign lvl_cmp   = cmp_en_q && !cmp_out_i;

  assign ev_mon    = reg_wr && sfr_wdata_i[rsc_pkg::BIT_POR] && !mon_en_q;
  assign ev_sw     = reg_wr && sfr_wdata_i[rsc_pkg::BIT_SW];
  assign ev_wdt    = in_run && wdt_timeout_i;

  assign ferr_wr    = program_store_write_enable_i && movx_wr_i && above_limit(movx_addr_i, size_sel_i);
  assign ferr_rd    = movc_rd_i && above_limit(movc_addr_i, size_sel_i);
  assign ferr_fetch = branch_fetch_i && above_limit(fetch_addr_i, size_sel_i);
  assign ev_ferr    = in_run && (ferr_wr || ferr_rd || ferr_fetch);

  assign power_grp = lvl_por || lvl_mon || ev_mon;
  assign any_level = lvl_por || lvl_mon || lvl_pin || lvl_mcd || lvl_cmp;
  assign trigger   = any_level || ev_mon || ev_sw || ev_wdt || ev_ferr;

  // Power-type causes win, since they make every other flag meaningless.
  // Each reset leaves exactly one flag set, the flag of the cause that won below.
  // power and monitor cause
  assign new_cause = power_grp ? 8'h01 << rsc_pkg::BIT_POR  :
                     lvl_pin   ? 8'h01 << rsc_pkg::BIT_PIN  :
                     lvl_mcd   ? 8'h01 << rsc_pkg::BIT_MCD  :
                     lvl_cmp   ? 8'h01 << rsc_pkg::BIT_CMP  :
                     ev_wdt    ? 8'h01 << rsc_pkg::BIT_WDT  :
                     ev_ferr   ? 8'h01 << rsc_pkg::BIT_FERR :
                     ev_sw     ? 8'h01 << rsc_pkg::BIT_SW   :
                                 8'h00;

  assign dly_done  = dly_cnt_q == rsc_pkg::RST_DELAY_W'(rsc_pkg::RST_DELAY_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // The sequencer holds reset while any level source stands, then counts the release
  // delay. Pulse sources are only taken while running, since the CPU that would make
  // them is halted in reset.
  always_comb begin
    state_d   = state_q;
    dly_cnt_d = dly_cnt_q;
    pend_d    = pend_q;
    cause_d   = cause_q;
    unique case (state_q)
      rsc_pkg::ST_RUN: begin
        if (trigger) begin
          state_d = rsc_pkg::ST_HOLD;
          pend_d  = new_cause;
        end
      end
      rsc_pkg::ST_HOLD: begin
        dly_cnt_d = '0;
        if (power_grp) begin
          pend_d = new_cause;
        end
        if (!any_level) begin
          state_d = rsc_pkg::ST_DELAY;
        end
      end
      rsc_pkg::ST_DELAY: begin
        dly_cnt_d = dly_cnt_q + 1'b1;
        if (any_level) begin
          // A new source during the delay restarts the sequence under its own cause.
          state_d = rsc_pkg::ST_HOLD;
          pend_d  = new_cause;
        end else if (dly_done) begin
          state_d = rsc_pkg::ST_RUN;
          cause_d = pend_d;
        end
      end
      default: begin
        state_d = rsc_pkg::ST_HOLD;
        pend_d  = 8'h01 << rsc_pkg::BIT_POR;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_q   <= rsc_pkg::ST_HOLD;
      dly_cnt_q <= '0;
      pend_q    <= rsc_pkg::CAUSE_RESET_VALUE;
      cause_q   <= rsc_pkg::CAUSE_RESET_VALUE;
    end else begin
      state_q   <= state_d;
      dly_cnt_q <= dly_cnt_d;
      pend_q    <= pend_d;
      cause_q   <= cause_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Enable bits

  // Enables survive every reset but power-on, so a firmware reset does not silently
  // switch off the supervision that firmware turned on.
  // clock loss enable
  assign mcd_en_d = lvl_por ? 1'b0 : (reg_wr ? sfr_wdata_i[rsc_pkg::BIT_MCD] : mcd_en_q);
  assign cmp_en_d = lvl_por ? 1'b0 : (reg_wr ? sfr_wdata_i[rsc_pkg::BIT_CMP] : cmp_en_q);
  assign mon_en_d = lvl_por ? 1'b0 : (reg_wr ? sfr_wdata_i[rsc_pkg::BIT_POR] : mon_en_q);

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      mcd_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
      mon_en_q <= 1'b0;
    end else begin
      mcd_en_q <= mcd_en_d;
      cmp_en_q <= cmp_en_d;
      mon_en_q <= mon_en_d;
    end
  end

  assign cw.detect_en = mcd_en_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  // Reads show flags while writes set enables, so firmware must never merge the two.
  // The read value is registered so that the bus sees a stable byte for a whole cycle.
  // top bit zero
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rdata_q <= rsc_pkg::CAUSE_RESET_VALUE;
    end else begin
      rdata_q <= {1'b0, cause_q[6:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin and system outputs

  // The pin is open drain: it is only ever pulled low, and only for power-type causes.
  // Other causes leave it released, so an outside observer never sees them on the pin.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pin_oe_q  <= 1'b1;
      pin_out_q <= 1'b0;
    end else begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= (state_d != rsc_pkg::ST_RUN) && pend_d[rsc_pkg::BIT_POR];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sys_rst_q     <= 1'b1;
      run_q         <= 1'b0;
      vector_q      <= rsc_pkg::RESET_VECTOR;
      wdt_restart_q <= 1'b1;
      wdt_tick_q    <= 1'b0;
    end else begin
      sys_rst_q     <= state_d != rsc_pkg::ST_RUN;
      run_q         <= state_d == rsc_pkg::ST_RUN;
      vector_q      <= rsc_pkg::RESET_VECTOR;
      wdt_restart_q <= state_d != rsc_pkg::ST_RUN;
      wdt_tick_q    <= cw.wdt_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock watcher

  // The watcher runs on mclk_i and treats the system clock as plain data.
  rsc_clock_watch #(
    .MCD_CYC (MCD_CYC)
  ) u_clock_watch (
    .mclk_i   (mclk_i),
    .nrst_i   (nrst_i),
    .system_clock_i (system_clock_i),
    .cw       (cw.watch)
  );

  assign sfr_rdata_o    = rdata_q;
  assign rst_pin_o      = pin_out_q;
  assign rst_pin_oe_o   = pin_oe_q;
  assign sys_rst_o      = sys_rst_q;
  assign cpu_run_o      = run_q;
  assign reset_vector_o = vector_q;
  assign vdd_mon_en_o   = mon_en_q;
  assign wdt_restart_o  = wdt_restart_q;
  assign wdt_tick_o     = wdt_tick_q;

endmodule

// *** sim/rsc_reset_source_controller_properties.sv ***
// Concurrent checks on the ports of the reset source controller.
`timescale 1ns/100ps
module rsc_reset_source_controller_properties #(
  parameter int unsigned MCD_CYC = rsc_pkg::MCD_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Watched inputs
  input  wire logic        sfr_sel_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic [1:0]  size_sel_i,
  input  wire logic        program_store_write_enable_i,
  input  wire logic        movx_wr_i,
  input  wire logic [15:0] movx_addr_i,
  input  wire logic        rst_pin_i,
  // Watched outputs
  input  wire logic [7:0]  sfr_rdata_o,
  input  wire logic        rst_pin_o,
  input  wire logic        rst_pin_oe_o,
  input  wire logic        sys_rst_o,
  input  wire logic        cpu_run_o,
  input  wire logic        vdd_mon_en_o,
  input  wire logic        wdt_restart_o,
  input  wire logic        wdt_tick_o
);
  logic [15:0] limit;
  logic [11:0] held_q;
  logic [11:0] held_d;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  assign limit = size_sel_i == rsc_pkg::SIZE_8K ? rsc_pkg::LIMIT_8K :
                 size_sel_i == rsc_pkg::SIZE_4K ? rsc_pkg::LIMIT_4K : rsc_pkg::LIMIT_2K;
  // Saturating count of cycles spent in reset, to measure the release delay.
  assign held_d = !sys_rst_o ? 12'h000 : (held_q == 12'hfff ? held_q : held_q + 12'h001);
  always_ff @(posedge mclk_i) begin
    held_q <= nrst_i ? held_d : 12'h000;
  end
  ////////////////////////////////////////////////////////////
  sequence s_taken;
    ##1 (sys_rst_o && !cpu_run_o);
  endsequence
  a_sw_force: assert property ((sfr_sel_i && sfr_wr_i && sfr_wdata_i[4] && cpu_run_o) |-> s_taken)
    else $error("software force did not reset");
  a_wdt_timeout: assert property ((wdt_timeout_i && cpu_run_o) |-> s_taken)
    else $error("watchdog timeout did not reset");
  a_flash_write: assert property ((movx_wr_i && program_store_write_enable_i && movx_addr_i > limit && cpu_run_o) |-> s_taken)
    else $error("illegal flash write did not reset");
  a_pin_reset: assert property ((!rst_pin_i && !rst_pin_oe_o) |-> s_taken)
    else $error("low pin did not reset");
  a_pin_quiet: assert property (rst_pin_oe_o |-> (sys_rst_o && !rst_pin_o))
    else $error("pin driven outside a reset");
  a_release_delay: assert property ($rose(cpu_run_o) |-> held_q >= rsc_pkg::RST_DELAY_CYC)
    else $error("execution started too early");
  a_flag_update: assert property (($changed(sfr_rdata_o) && $past(nrst_i)) |-> cpu_run_o)
    else $error("cause flags changed while in reset");
  a_flag_onehot: assert property ($onehot0(sfr_rdata_o) && !sfr_rdata_o[7])
    else $error("cause flags not one-hot");
  a_mon_enable: assert property ($rose(vdd_mon_en_o) |-> ##[0:1] sys_rst_o)
    else $error("monitor enable did not reset");
  a_wdt_restart: assert property (sys_rst_o |-> wdt_restart_o)
    else $error("watchdog not restarted in reset");
  a_tick_pulse: assert property (wdt_tick_o |=> !wdt_tick_o)
    else $error("watchdog tick longer than one cycle");
endmodule

bind rsc_reset_source_controller rsc_reset_source_controller_properties #(.MCD_CYC(MCD_CYC)) rsc_props_inst (
  .mclk_i, .nrst_i, .sfr_sel_i, .sfr_wr_i, .sfr_wdata_i, .wdt_timeout_i, .size_sel_i, .program_store_write_enable_i,
  .movx_wr_i, .movx_addr_i, .rst_pin_i, .sfr_rdata_o, .rst_pin_o, .rst_pin_oe_o, .sys_rst_o,
  .cpu_run_o, .vdd_mon_en_o, .wdt_restart_o, .wdt_tick_o);

// *** sim/rsc_far_model.sv ***
// Far side model: system clock source and the pulled-up reset pin.
`timescale 1ns/100ps
module rsc_far_model (
  // Clock
  input  wire logic mclk_i,
  // Bench controls
  input  wire logic clk_run_i,
  input  wire logic ext_low_i,
  // Device pin
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe_o,
  output logic      rst_pin_i,
  output logic      system_clock_o
);
  logic [2:0] div_q = 3'h0;
  initial system_clock_o = 1'b0;
  // The pin has a pull-up, so it reads high unless someone pulls it low.
  assign rst_pin_i = ((rst_pin_oe_o && !rst_pin_o) || ext_low_i) ? 1'b0 : 1'b1;
  // A stopped clock just holds its level, which is exactly a lost clock.
  always @(posedge mclk_i) begin
    if (clk_run_i) begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h7) system_clock_o <= !system_clock_o;
    end
  end
endmodule

// *** sim/rsc_reset_source_controller_tb.sv ***
// Self-checking bench of the reset source controller.
`timescale 1ns/100ps
module rsc_reset_source_controller_tb;
  typedef struct packed {
    logic [3:0]  kind;
    logic [1:0]  size;
    logic [15:0] addr;
    logic [7:0]  exp;
  } rsc_row_type;
  logic        mclk_i, nrst_i, sfr_sel_i, sfr_wr_i, por_i, vdd_low_i, system_clock_i, cmp_out_i, wdt_timeout_i;
  logic        program_store_write_enable_i, movx_wr_i, movc_rd_i, branch_fetch_i, rst_pin_i, rst_pin_o, rst_pin_oe_o;
  logic        sys_rst_o, cpu_run_o, vdd_mon_en_o, wdt_restart_o, wdt_tick_o, clk_run, ext_low;
  logic [1:0]  size_sel_i;
  logic [7:0]  sfr_wdata_i, sfr_rdata_o;
  logic [15:0] addr_q, reset_vector_o;
  int          error_cnt, checked, cycles, n;
  // Kinds: 0 write, 1 watchdog, 2/3 flash write with/without enable, 4 code read, 5 branch,
  // 6 pin, 7 comparator, 8 clock stop, 9 supply low. An expected value of zero means no reset.
  // The comparator stays high (settled) before it is made a source.
  rsc_row_type rows [20] = '{
    '{4'h0, 2'h0, 16'h0010, 8'h10}, '{4'h0, 2'h0, 16'h0000, 8'h00}, '{4'h0, 2'h0, 16'h0080, 8'h00},
    '{4'h1, 2'h0, 16'h0000, 8'h08}, '{4'h2, 2'h0, 16'h1dff, 8'h00}, '{4'h2, 2'h0, 16'h1e00, 8'h40},
    '{4'h3, 2'h0, 16'hffff, 8'h00}, '{4'h4, 2'h1, 16'h0fff, 8'h00}, '{4'h4, 2'h1, 16'h1000, 8'h40},
    '{4'h5, 2'h2, 16'h07ff, 8'h00}, '{4'h5, 2'h2, 16'h0800, 8'h40}, '{4'h5, 2'h3, 16'h0800, 8'h40},
    '{4'h6, 2'h0, 16'h0000, 8'h01}, '{4'h0, 2'h0, 16'h0002, 8'h02}, '{4'h0, 2'h0, 16'h0002, 8'h00},
    '{4'h9, 2'h0, 16'h0000, 8'h02}, '{4'h0, 2'h0, 16'h0022, 8'h00}, '{4'h7, 2'h0, 16'h0000, 8'h20},
    '{4'h0, 2'h0, 16'h0026, 8'h00}, '{4'h8, 2'h0, 16'h0000, 8'h04}};

  rsc_reset_source_controller #(.MCD_CYC(40)) rsc_reset_source_controller_inst (
    .mclk_i, .nrst_i, .sfr_sel_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .por_i, .vdd_low_i, .system_clock_i,
    .cmp_out_i, .wdt_timeout_i, .size_sel_i, .program_store_write_enable_i, .movx_wr_i, .movx_addr_i(addr_q), .movc_rd_i,
    .movc_addr_i(addr_q), .branch_fetch_i, .fetch_addr_i(addr_q), .rst_pin_i, .rst_pin_o, .rst_pin_oe_o,
    .sys_rst_o, .cpu_run_o, .reset_vector_o, .vdd_mon_en_o, .wdt_restart_o, .wdt_tick_o);
  rsc_far_model rsc_far_model_inst (.mclk_i, .clk_run_i(clk_run), .ext_low_i(ext_low), .rst_pin_o,
    .rst_pin_oe_o, .rst_pin_i, .system_clock_o(system_clock_i));
  ////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = !mclk_i;
  end
  task automatic stop_test();
    $display("Errors: %0d, comparisons: %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_run();
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (cpu_run_o !== 1'b1 && n < 3000);
  endtask
  task automatic run_row(input rsc_row_type r);
    @(posedge mclk_i);
    size_sel_i     <= r.size;
    addr_q         <= r.addr;
    sfr_wdata_i    <= r.addr[7:0];
    sfr_sel_i      <= r.kind == 4'h0;
    sfr_wr_i       <= r.kind == 4'h0;
    wdt_timeout_i  <= r.kind == 4'h1;
    program_store_write_enable_i         <= r.kind == 4'h2;
    movx_wr_i      <= r.kind inside {4'h2, 4'h3};
    movc_rd_i      <= r.kind == 4'h4;
    branch_fetch_i <= r.kind == 4'h5;
    ext_low        <= r.kind == 4'h6;
    cmp_out_i      <= r.kind != 4'h7;
    clk_run        <= r.kind != 4'h8;
    vdd_low_i      <= r.kind == 4'h9;
    repeat (r.kind == 4'h8 ? 80 : (r.kind > 4'h5 ? 20 : 1)) @(posedge mclk_i);
    {sfr_sel_i, sfr_wr_i, wdt_timeout_i, movx_wr_i, movc_rd_i, branch_fetch_i, ext_low, vdd_low_i} <= '0;
    {cmp_out_i, clk_run} <= 2'b11;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (sys_rst_o !== 1'b1 && n < 12);
    chk({sys_rst_o, rst_pin_oe_o, wdt_restart_o}, {r.exp != 8'h00, r.exp == 8'h02, r.exp != 8'h00});
    if (r.exp != 8'h00) begin
      wait_run();
      @(negedge mclk_i);
      chk(sfr_rdata_o, r.exp);
    end
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    {nrst_i, sfr_sel_i, sfr_wr_i, por_i, vdd_low_i, wdt_timeout_i, program_store_write_enable_i} = '0;
    {movx_wr_i, movc_rd_i, branch_fetch_i, ext_low, size_sel_i, sfr_wdata_i, addr_q} = '0;
    {cmp_out_i, clk_run} = 2'b11;
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(sfr_rdata_o, 8'h02);
    chk({rst_pin_oe_o, vdd_mon_en_o, sys_rst_o, wdt_restart_o}, 4'b1011);
    chk(reset_vector_o, 16'h0000);
    @(posedge mclk_i);
    nrst_i <= 1'b1;
    wait_run();
    chk(n >= rsc_pkg::RST_DELAY_CYC, 1'b1);
    for (int i = 0; i < 20; i++) begin
      run_row(rows[i]);
    end
    chk(vdd_mon_en_o, 1'b1);
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    @(posedge mclk_i);
    nrst_i <= 1'b1;
    wait_run();
    @(negedge mclk_i);
    chk({sfr_rdata_o, vdd_mon_en_o}, 9'h004);
    run_row('{4'h0, 2'h0, 16'h0026, 8'h02});
    @(posedge mclk_i);
    por_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({sys_rst_o, rst_pin_oe_o, vdd_mon_en_o}, 3'b110);
    @(posedge mclk_i);
    por_i <= 1'b0;
    wait_run();
    @(negedge mclk_i);
    chk({sfr_rdata_o, vdd_mon_en_o}, 9'h004);
    n = 0;
    repeat (384) begin
      @(negedge mclk_i);
      n += wdt_tick_o;
    end
    chk(n, 2);
    stop_test();
  end
endmodule
